// ==== design/atacd_decoder.sv ====
// Task-file command decoder: register file, opcode decode and completion.
`timescale 1ns/1ps
`include "atacd_map.svh"
module atacd_decoder (
  input wire logic CLK, // 25 MHz device clock
  input wire logic RESETN, // Asynchronous reset
  input wire logic TF_WR, // Task-file write strobe
  input wire logic TF_RD, // Task-file read strobe
  input wire logic [2:0] TF_ADDR, // Task-file register index
  input wire logic [7:0] TF_WDATA, // Write data
  output logic [7:0] TF_RDATA, // Registered read data
  input wire atacd_pkg::atacd_pm_t PWR_STATE, // Power state from power manager
  input wire logic CMD_DONE, // Engine finished the issued command
  input wire logic [7:0] DIAG_CODE, // Diagnostic result, valid with done
  output atacd_pkg::atacd_cmd_t CMD, // Issued command with masked fields
  output logic CMD_GO, // One-cycle issue pulse
  output logic BSY, // Busy status
  output logic ERR, // Error status
  output logic INTRQ // One-cycle completion interrupt
);
  import atacd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DEC = 2'b01, ST_WAIT = 2'b10, ST_FIN = 2'b11
  } atacd_state_t;

  function automatic atacd_class_t atacd_decode(input logic [7:0] op);
    atacd_class_t c;
    c = CL_NONE;
    if (op == OP_PWRQ_A || op == OP_PWRQ_B) c = CL_PWRQ;
    else if (op == OP_DIAG) c = CL_DIAG;
    else if (op == OP_IDENT) c = CL_IDENT;
    else if (op == OP_IDLE_A || op == OP_IDLE_B) c = CL_IDLE;
    else if (op == OP_IDLEI_A || op == OP_IDLEI_B) c = CL_IDLEI;
    else if (op == OP_STBY_A || op == OP_STBY_B) c = CL_STBY;
    else if (op == OP_STBYI_A || op == OP_STBYI_B) c = CL_STBYI;
    else if (op == OP_SLEEP_A || op == OP_SLEEP_B) c = CL_SLEEP;
    else if (op == OP_INIT) c = CL_INIT;
    else if (op == OP_RD_DMA || op == OP_RD_MULT) c = CL_READ;
    else if (op == OP_RD_SEC_A || op == OP_RD_SEC_B) c = CL_READ;
    else if (op == OP_VFY_A || op == OP_VFY_B) c = CL_VERIFY;
    else if (op == OP_WR_DMA || op == OP_WR_MULT) c = CL_WRITE;
    else if (op == OP_WR_SEC_A || op == OP_WR_SEC_B) c = CL_WRITE;
    else if (op == OP_SETF) c = CL_SETF;
    else if (op == OP_SETM) c = CL_SETM;
    else if (op[7:4] == NIB_SEEK) c = CL_SEEK;
    else if (op[7:4] == NIB_RECAL) c = CL_RECAL;
    return c;
  endfunction

  function automatic atacd_use_t atacd_uses(input atacd_class_t c);
    atacd_use_t u;
    u = '0;
    u.fr = (c == CL_SETF);
    u.sc = (c == CL_IDLE) || (c == CL_INIT) || (c == CL_SETM) || (c == CL_READ) ||
           (c == CL_VERIFY) || (c == CL_WRITE);
    u.sn = (c == CL_READ) || (c == CL_VERIFY) || (c == CL_WRITE) || (c == CL_SEEK);
    u.cy = u.sn;
    u.dh_full = u.sn || (c == CL_INIT);
    u.lba = u.sn;
    return u;
  endfunction

  atacd_state_t st_ff, nxt_st;
  logic [7:0] feat_ff, count_ff, sector_ff, cyl_lo_ff, cyl_hi_ff, drvhd_ff, err_ff;
  atacd_class_t cls_ff;
  logic [7:0] op_ff;
  logic busy_ff, errst_ff, intrq_ff, go_ff;
  atacd_cmd_t cmd_ff;
  logic [7:0] rdata_ff;
  logic host_wr, cmd_wr, pm_asleep;
  atacd_use_t use_d;

  assign host_wr = TF_WR && !busy_ff;
  assign cmd_wr = host_wr && (TF_ADDR == `ATACD_IX_CMD);
  assign pm_asleep = (PWR_STATE != PM_IDLE);
  assign use_d = atacd_uses(cls_ff);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (cmd_wr) nxt_st = ST_DEC;
      end
      ST_DEC: begin
        if (cls_ff == CL_PWRQ || cls_ff == CL_NONE) nxt_st = ST_FIN;
        else nxt_st = ST_WAIT;
      end
      ST_WAIT: begin
        if (CMD_DONE) nxt_st = ST_FIN;
      end
      ST_FIN: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) st_ff <= ST_IDLE;
    else st_ff <= nxt_st;
  end

  // Parameter registers are only writable while not busy.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      feat_ff <= `ATACD_RST_BYTE;
      sector_ff <= `ATACD_RST_CNT;
      cyl_lo_ff <= `ATACD_RST_BYTE;
      cyl_hi_ff <= `ATACD_RST_BYTE;
      drvhd_ff <= `ATACD_RST_BYTE;
    end else if (host_wr) begin
      unique case (TF_ADDR)
        `ATACD_IX_ERROR: feat_ff <= TF_WDATA;
        `ATACD_IX_SECTOR: sector_ff <= TF_WDATA;
        `ATACD_IX_CYL_LO: cyl_lo_ff <= TF_WDATA;
        `ATACD_IX_CYL_HI: cyl_hi_ff <= TF_WDATA;
        `ATACD_IX_DRVHD: drvhd_ff <= TF_WDATA;
        default: ;
      endcase
    end
  end

  // Count is written by the host or loaded by the power-mode query.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) count_ff <= `ATACD_RST_CNT;
    else if (st_ff == ST_DEC && cls_ff == CL_PWRQ) begin
      count_ff <= pm_asleep ? `ATACD_PM_ASLEEP : `ATACD_PM_IDLE;
    end else if (host_wr && TF_ADDR == `ATACD_IX_COUNT) count_ff <= TF_WDATA;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      op_ff <= `ATACD_RST_BYTE;
      cls_ff <= CL_NONE;
    end else if (cmd_wr) begin
      op_ff <= TF_WDATA;
      cls_ff <= atacd_decode(TF_WDATA);
    end
  end

  // Busy rises on the command write and falls when the interrupt is raised.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) busy_ff <= 1'b0;
    else if (cmd_wr) busy_ff <= 1'b1;
    else if (st_ff == ST_FIN) busy_ff <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) intrq_ff <= 1'b0;
    else intrq_ff <= (st_ff == ST_FIN);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      err_ff <= `ATACD_DIAG_OK;
      errst_ff <= 1'b0;
    end else if (cmd_wr) begin
      errst_ff <= 1'b0;
    end else if (st_ff == ST_DEC && cls_ff == CL_NONE) begin
      err_ff <= `ATACD_ERR_ABORT;
      errst_ff <= 1'b1;
    end else if (st_ff == ST_WAIT && CMD_DONE && cls_ff == CL_DIAG) begin
      err_ff <= DIAG_CODE;
      errst_ff <= (DIAG_CODE != `ATACD_DIAG_OK);
    end
  end

  // Parameters the opcode does not use are zeroed before issue.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_ff <= '0;
      go_ff <= 1'b0;
    end else begin
      go_ff <= (st_ff == ST_DEC) && (cls_ff != CL_PWRQ) && (cls_ff != CL_NONE);
      if (st_ff == ST_DEC) begin
        cmd_ff.cls <= (cls_ff == CL_IDENT) ? CL_READ : cls_ff;
        cmd_ff.opcode <= op_ff;
        cmd_ff.features <= use_d.fr ? feat_ff : 8'h00;
        cmd_ff.count <= use_d.sc ? count_ff : 8'h00;
        cmd_ff.sector <= use_d.sn ? sector_ff : 8'h00;
        cmd_ff.cylinder <= use_d.cy ? {cyl_hi_ff, cyl_lo_ff} : 16'h0000;
        cmd_ff.drive <= drvhd_ff[`ATACD_DRIVE_BIT];
        cmd_ff.head <= use_d.dh_full ? drvhd_ff[3:0] : 4'h0;
        cmd_ff.lba_mode <= use_d.lba && drvhd_ff[`ATACD_LBA_BIT];
        cmd_ff.one_sector <= (cls_ff == CL_IDENT);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) rdata_ff <= `ATACD_RST_BYTE;
    else if (TF_RD) begin
      unique case (TF_ADDR)
        `ATACD_IX_ERROR: rdata_ff <= err_ff;
        `ATACD_IX_COUNT: rdata_ff <= count_ff;
        `ATACD_IX_SECTOR: rdata_ff <= sector_ff;
        `ATACD_IX_CYL_LO: rdata_ff <= cyl_lo_ff;
        `ATACD_IX_CYL_HI: rdata_ff <= cyl_hi_ff;
        `ATACD_IX_DRVHD: rdata_ff <= drvhd_ff;
        `ATACD_IX_CMD: rdata_ff <= {busy_ff, !busy_ff, 5'h00, errst_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign TF_RDATA = rdata_ff;
  assign CMD = cmd_ff;
  assign CMD_GO = go_ff;
  assign BSY = busy_ff;
  assign ERR = errst_ff;
  assign INTRQ = intrq_ff;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_pwrq_asleep: assert property (
    (st_ff == ST_DEC && cls_ff == CL_PWRQ && pm_asleep) |=>
      (count_ff == `ATACD_PM_ASLEEP && busy_ff) ##1 (intrq_ff && !busy_ff))
    else $error("Sleep power query did not report 00h.");
  a_pwrq_idle: assert property (
    (st_ff == ST_DEC && cls_ff == CL_PWRQ && !pm_asleep) |=>
      (count_ff == `ATACD_PM_IDLE && busy_ff) ##1 (intrq_ff && !busy_ff))
    else $error("Idle power query did not report FFh.");
  a_pwrq_alias: assert property (
    (cmd_wr && (TF_WDATA == OP_PWRQ_A || TF_WDATA == OP_PWRQ_B)) |=> ##2 intrq_ff && !go_ff)
    else $error("Power query alias not completed internally.");
  a_diag_decode: assert property (
    (cmd_wr && TF_WDATA == OP_DIAG) |=> ##1 (go_ff && cmd_ff.cls == CL_DIAG && cmd_ff.head == 4'h0))
    else $error("Diagnostic opcode misdecoded.");
  a_pwr_pairs: assert property (
    (cmd_wr && TF_WDATA == OP_SLEEP_B) |=> cls_ff == CL_SLEEP)
    else $error("Alternate sleep opcode misdecoded.");
  a_feat_mask: assert property (
    (go_ff && cmd_ff.cls != CL_SETF) |-> cmd_ff.features == 8'h00)
    else $error("Features passed to a command that ignores them.");
  a_count_mask: assert property (
    (go_ff && (cmd_ff.cls == CL_SETF || cmd_ff.cls == CL_SEEK)) |-> cmd_ff.count == 8'h00)
    else $error("Count passed to a command that ignores it.");
  a_lba_scope: assert property (
    (go_ff && cmd_ff.lba_mode) |-> (cmd_ff.cls inside {CL_READ, CL_VERIFY, CL_WRITE, CL_SEEK}))
    else $error("Block addressing on an unsupported command.");
  a_seek_nibble: assert property (
    (cmd_wr && TF_WDATA[7:4] == NIB_SEEK) |=> cls_ff == CL_SEEK)
    else $error("Seek nibble misdecoded.");
  a_head_mask: assert property (
    (go_ff && (cmd_ff.cls inside {CL_SETF, CL_IDLE, CL_SLEEP, CL_RECAL})) |-> cmd_ff.head == 4'h0)
    else $error("Head passed to a drive-only command.");
  a_diag_result: assert property (
    (st_ff == ST_WAIT && CMD_DONE && cls_ff == CL_DIAG) |=> (err_ff == $past(DIAG_CODE)) ##1 intrq_ff)
    else $error("Diagnostic result not placed in error register.");
  a_abort_bad: assert property (
    (st_ff == ST_DEC && cls_ff == CL_NONE) |=> (err_ff == `ATACD_ERR_ABORT && errst_ff && !go_ff) ##1 intrq_ff)
    else $error("Unsupported opcode not aborted.");

  a_pwrq_same: assert property (
    (cmd_wr && (TF_WDATA == OP_PWRQ_A || TF_WDATA == OP_PWRQ_B)) |=> cls_ff == CL_PWRQ)
    else $error("Power query opcode misdecoded.");
  a_idle_pair: assert property (
    (cmd_wr && (TF_WDATA == OP_IDLE_A || TF_WDATA == OP_IDLE_B)) |=> cls_ff == CL_IDLE)
    else $error("Idle opcode pair misdecoded.");
  a_stby_pair: assert property (
    (cmd_wr && (TF_WDATA == OP_STBY_A || TF_WDATA == OP_STBY_B)) |=> cls_ff == CL_STBY)
    else $error("Standby opcode pair misdecoded.");
  a_immed_pair: assert property (
    (cmd_wr && (TF_WDATA == OP_IDLEI_B || TF_WDATA == OP_STBYI_B)) |=>
      (cls_ff == CL_IDLEI || cls_ff == CL_STBYI))
    else $error("Immediate power opcode misdecoded.");
  a_sleep_pair: assert property (
    (cmd_wr && TF_WDATA == OP_SLEEP_A) |=> cls_ff == CL_SLEEP)
    else $error("Sleep opcode misdecoded.");
  a_feat_pass: assert property (
    (go_ff && cmd_ff.cls == CL_SETF) |-> cmd_ff.features == feat_ff)
    else $error("Features not passed to set-features.");
  a_init_decode: assert property (
    (cmd_wr && TF_WDATA == OP_INIT) |=> cls_ff == CL_INIT)
    else $error("Drive parameter opcode misdecoded.");
  a_count_pass: assert property (
    (go_ff && !cmd_ff.one_sector &&
      (cmd_ff.cls inside {CL_IDLE, CL_INIT, CL_SETM, CL_READ, CL_VERIFY, CL_WRITE})) |->
      cmd_ff.count == count_ff)
    else $error("Count not passed to a command that uses it.");
  a_busy_refuse: assert property (
    (TF_WR && busy_ff && TF_ADDR == `ATACD_IX_COUNT && cls_ff != CL_PWRQ) |=> $stable(count_ff))
    else $error("Count written while busy.");
  a_lba_pass: assert property (
    (go_ff && !cmd_ff.one_sector && (cmd_ff.cls inside {CL_READ, CL_VERIFY, CL_WRITE, CL_SEEK})) |->
      cmd_ff.lba_mode == drvhd_ff[`ATACD_LBA_BIT])
    else $error("Block addressing flag lost.");
  a_recal_nibble: assert property (
    (cmd_wr && TF_WDATA[7:4] == NIB_RECAL) |=> cls_ff == CL_RECAL)
    else $error("Recalibrate nibble misdecoded.");
  a_full_head: assert property (
    (go_ff && !cmd_ff.one_sector &&
      (cmd_ff.cls inside {CL_READ, CL_VERIFY, CL_WRITE, CL_SEEK, CL_INIT})) |->
      cmd_ff.head == drvhd_ff[3:0])
    else $error("Head dropped from a full drive/head command.");
  a_verify_decode: assert property (
    (cmd_wr && (TF_WDATA == OP_VFY_A || TF_WDATA == OP_VFY_B)) |=> cls_ff == CL_VERIFY)
    else $error("Verify opcode misdecoded.");
  a_sector_pass: assert property (
    (go_ff && !cmd_ff.one_sector && (cmd_ff.cls inside {CL_READ, CL_VERIFY, CL_WRITE, CL_SEEK})) |->
      (cmd_ff.sector == sector_ff && cmd_ff.cylinder == {cyl_hi_ff, cyl_lo_ff}))
    else $error("Sector or cylinder not passed.");
  a_drive_pass: assert property (
    go_ff |-> cmd_ff.drive == drvhd_ff[`ATACD_DRIVE_BIT])
    else $error("Drive-select bit not passed.");
  a_cmd_index: assert property (
    (host_wr && TF_ADDR != `ATACD_IX_CMD) |=> (st_ff == ST_IDLE && !busy_ff))
    else $error("Parameter write started a command.");
  a_diag_err: assert property (
    (st_ff == ST_WAIT && CMD_DONE && cls_ff == CL_DIAG) |=>
      errst_ff == (err_ff != `ATACD_DIAG_OK))
    else $error("Diagnostic error status wrong.");
  a_ident_read: assert property (
    (cmd_wr && TF_WDATA == OP_IDENT) |=> ##1
      (go_ff && cmd_ff.cls == CL_READ && cmd_ff.one_sector && cmd_ff.count == 8'h00))
    else $error("Identify not issued as a one-sector read.");
  a_busy_write: assert property (
    cmd_wr |=> (busy_ff && st_ff == ST_DEC))
    else $error("Busy not raised on command write.");
  a_intrq_idle: assert property (
    intrq_ff |-> (!busy_ff && st_ff == ST_IDLE))
    else $error("Interrupt raised while still busy.");

  c_pwrq_sleep: cover property (st_ff == ST_DEC && cls_ff == CL_PWRQ && pm_asleep);
  c_diag_done: cover property (st_ff == ST_WAIT && CMD_DONE && cls_ff == CL_DIAG);
  c_abort: cover property (st_ff == ST_DEC && cls_ff == CL_NONE);
  c_ident_issue: cover property (go_ff && cmd_ff.one_sector);
  c_write_refused: cover property (TF_WR && busy_ff);
endmodule

// ==== design/atacd_map.svh ====
// Task-file register indices, field positions, reset values and fixed codes.
`ifndef ATACD_MAP_SVH
`define ATACD_MAP_SVH
`define ATACD_IX_DATA 3'h0
`define ATACD_IX_ERROR 3'h1
`define ATACD_IX_COUNT 3'h2
`define ATACD_IX_SECTOR 3'h3
`define ATACD_IX_CYL_LO 3'h4
`define ATACD_IX_CYL_HI 3'h5
`define ATACD_IX_DRVHD 3'h6
`define ATACD_IX_CMD 3'h7
`define ATACD_DRIVE_BIT 4
`define ATACD_LBA_BIT 6
`define ATACD_ST_BSY 7
`define ATACD_ST_DRDY 6
`define ATACD_ST_ERR 0
`define ATACD_RST_BYTE 8'h00
`define ATACD_RST_CNT 8'h01
`define ATACD_PM_ASLEEP 8'h00
`define ATACD_PM_IDLE 8'hFF
`define ATACD_ERR_ABORT 8'h04
`define ATACD_DIAG_OK 8'h01
`endif

// ==== design/atacd_pkg.sv ====
// Types and opcodes shared by the task-file command decoder.
package atacd_pkg;
  typedef enum logic [4:0] {
    CL_NONE = 5'h00, CL_PWRQ = 5'h01, CL_DIAG = 5'h02, CL_IDENT = 5'h03,
    CL_IDLE = 5'h04, CL_IDLEI = 5'h05, CL_STBY = 5'h06, CL_STBYI = 5'h07,
    CL_SLEEP = 5'h08, CL_INIT = 5'h09, CL_READ = 5'h0A, CL_VERIFY = 5'h0B,
    CL_RECAL = 5'h0C, CL_SEEK = 5'h0D, CL_SETF = 5'h0E, CL_SETM = 5'h0F,
    CL_WRITE = 5'h10
  } atacd_class_t;
  typedef enum logic [1:0] {
    PM_IDLE = 2'b00, PM_SLEEP = 2'b01, PM_ENTER = 2'b10, PM_WAKE = 2'b11
  } atacd_pm_t;
  typedef struct packed {
    logic fr;
    logic sc;
    logic sn;
    logic cy;
    logic dh_full;
    logic lba;
  } atacd_use_t;
  typedef struct packed {
    atacd_class_t cls;
    logic [7:0] opcode;
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] sector;
    logic [15:0] cylinder;
    logic drive;
    logic [3:0] head;
    logic lba_mode;
    logic one_sector;
  } atacd_cmd_t;
  localparam logic [7:0] OP_PWRQ_A = 8'h98;
  localparam logic [7:0] OP_PWRQ_B = 8'hE5;
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_IDENT = 8'hEC;
  localparam logic [7:0] OP_IDLE_A = 8'hE3;
  localparam logic [7:0] OP_IDLE_B = 8'h97;
  localparam logic [7:0] OP_IDLEI_A = 8'hE1;
  localparam logic [7:0] OP_IDLEI_B = 8'h95;
  localparam logic [7:0] OP_STBY_A = 8'hE2;
  localparam logic [7:0] OP_STBY_B = 8'h96;
  localparam logic [7:0] OP_STBYI_A = 8'hE0;
  localparam logic [7:0] OP_STBYI_B = 8'h94;
  localparam logic [7:0] OP_SLEEP_A = 8'hE6;
  localparam logic [7:0] OP_SLEEP_B = 8'h99;
  localparam logic [7:0] OP_INIT = 8'h91;
  localparam logic [7:0] OP_RD_DMA = 8'hC8;
  localparam logic [7:0] OP_RD_MULT = 8'hC4;
  localparam logic [7:0] OP_RD_SEC_A = 8'h20;
  localparam logic [7:0] OP_RD_SEC_B = 8'h21;
  localparam logic [7:0] OP_VFY_A = 8'h40;
  localparam logic [7:0] OP_VFY_B = 8'h41;
  localparam logic [7:0] OP_SETF = 8'hEF;
  localparam logic [7:0] OP_SETM = 8'hC6;
  localparam logic [7:0] OP_WR_DMA = 8'hCA;
  localparam logic [7:0] OP_WR_MULT = 8'hC5;
  localparam logic [7:0] OP_WR_SEC_A = 8'h30;
  localparam logic [7:0] OP_WR_SEC_B = 8'h31;
  localparam logic [3:0] NIB_SEEK = 4'h7;
  localparam logic [3:0] NIB_RECAL = 4'h1;
endpackage

// ==== dv/atacd_engine_model.sv ====
// Command engine model that answers each issued command after a set delay.
`timescale 1ns/1ps
module atacd_engine_model (
  input wire logic CLK, // Device clock
  input wire logic RESETN, // Reset, active low
  input wire logic CMD_GO, // Issue pulse from the decoder
  input wire logic [3:0] DELAY, // Completion pulse comes DELAY plus one cycles after the issue pulse
  input wire logic [7:0] CODE, // Diagnostic result to return
  output logic CMD_DONE, // Completion pulse
  output logic [7:0] DIAG_CODE // Result, valid with completion only
);
  logic [4:0] cnt_ff;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_ff <= 5'h00;
    end else if (CMD_GO) begin
      cnt_ff <= {1'b0, DELAY} + 5'h01;
    end else if (cnt_ff != 5'h00) begin
      cnt_ff <= cnt_ff - 5'h01;
    end
  end
  assign CMD_DONE = (cnt_ff == 5'h01);
  // Outside completion the result lines show a wrong value on purpose.
  assign DIAG_CODE = CMD_DONE ? CODE : ~CODE;
endmodule

// ==== dv/tb_top.sv ====
// Self-checking testbench for the task-file command decoder.
`timescale 1ns/1ps
`include "atacd_map.svh"
module tb_top;
  import atacd_pkg::*;
  logic clk, rst_n, tf_wr, tf_rd, cmd_go, bsy, err, intrq, cmd_done, go;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata, tf_rdata, diag_code, eng_code;
  logic [3:0] eng_delay;
  atacd_pm_t pwr_state;
  atacd_cmd_t cmd, c;
  int mismatches, n_checks, i;
  logic [7:0] pv [1:6] = '{8'hAA, 8'h55, 8'h33, 8'h34, 8'h12, 8'h5B};
  // Opcode, class, then used fields: features, count, sector, cylinder, head, block mode.
  logic [23:0] tbl [29] = '{24'hE3_04_10, 24'h97_04_10, 24'hE1_05_00, 24'h95_05_00, 24'hE2_06_00,
    24'h96_06_00, 24'hE0_07_00, 24'h94_07_00, 24'hE6_08_00, 24'h99_08_00, 24'h91_09_12, 24'hC8_0A_1F,
    24'hC4_0A_1F, 24'h20_0A_1F, 24'h21_0A_1F, 24'h40_0B_1F, 24'h41_0B_1F, 24'hCA_10_1F, 24'hC5_10_1F,
    24'h30_10_1F, 24'h31_10_1F, 24'h7A_0D_0F, 24'h70_0D_0F, 24'h1F_0C_00, 24'h10_0C_00, 24'hEF_0E_20,
    24'hC6_0F_10, 24'hEC_0A_00, 24'h90_02_00};
  logic [7:0] bad [3] = '{8'h00, 8'h50, 8'hFF};

  atacd_decoder dut (.CLK(clk), .RESETN(rst_n), .TF_WR(tf_wr), .TF_RD(tf_rd), .TF_ADDR(tf_addr),
    .TF_WDATA(tf_wdata), .TF_RDATA(tf_rdata), .PWR_STATE(pwr_state), .CMD_DONE(cmd_done),
    .DIAG_CODE(diag_code), .CMD(cmd), .CMD_GO(cmd_go), .BSY(bsy), .ERR(err), .INTRQ(intrq));
  atacd_engine_model eng (.CLK(clk), .RESETN(rst_n), .CMD_GO(cmd_go), .DELAY(eng_delay),
    .CODE(eng_code), .CMD_DONE(cmd_done), .DIAG_CODE(diag_code));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    tf_wr <= 1'b1;
    tf_addr <= a;
    tf_wdata <= v;
    @(posedge clk);
    tf_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    tf_rd <= 1'b1;
    tf_addr <= a;
    @(posedge clk);
    tf_rd <= 1'b0;
    #1;
    chk(tf_rdata, exp);
  endtask

  task automatic wait_done();
    go = 1'b0;
    c = '0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (cmd_go === 1'b1) begin
        go = 1'b1;
        c = cmd;
      end
      if (intrq === 1'b1) break;
    end
    chk({7'h00, intrq}, 8'h01);
  endtask

  task automatic run(input logic [7:0] op, input atacd_pm_t pm);
    @(posedge clk);
    pwr_state <= pm;
    wr(`ATACD_IX_CMD, op);
    #1;
    chk({7'h00, bsy}, 8'h01);
    wait_done();
  endtask

  function automatic atacd_cmd_t exp_cmd(input logic [23:0] e);
    atacd_cmd_t x;
    x = '0;
    x.cls = atacd_class_t'(e[12:8]);
    x.opcode = e[23:16];
    x.features = e[5] ? pv[1] : 8'h00;
    x.count = e[4] ? pv[2] : 8'h00;
    x.sector = e[3] ? pv[3] : 8'h00;
    x.cylinder = e[2] ? {pv[5], pv[4]} : 16'h0000;
    x.drive = pv[6][4];
    x.head = e[1] ? pv[6][3:0] : 4'h0;
    x.lba_mode = e[0] & pv[6][6];
    x.one_sector = (e[23:16] == OP_IDENT);
    return x;
  endfunction

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    tf_wr = 1'b0;
    tf_rd = 1'b0;
    tf_addr = 3'h0;
    tf_wdata = 8'h00;
    pwr_state = PM_IDLE;
    eng_delay = 4'h2;
    eng_code = `ATACD_DIAG_OK;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`ATACD_IX_COUNT, `ATACD_RST_CNT);
    rdchk(`ATACD_IX_SECTOR, `ATACD_RST_CNT);
    rdchk(`ATACD_IX_ERROR, `ATACD_DIAG_OK);
    rdchk(`ATACD_IX_CMD, 8'h40);
    for (i = 1; i < 7; i++) wr(i[2:0], pv[i]);
    for (i = 2; i < 7; i++) rdchk(i[2:0], pv[i]);
    rdchk(`ATACD_IX_ERROR, `ATACD_DIAG_OK);
    for (i = 0; i < 8; i++) begin
      run(i[0] ? OP_PWRQ_B : OP_PWRQ_A, atacd_pm_t'(i[2:1]));
      chk({7'h00, go}, 8'h00);
      rdchk(`ATACD_IX_COUNT, (i[2:1] == 2'b00) ? `ATACD_PM_IDLE : `ATACD_PM_ASLEEP);
    end
    rdchk(`ATACD_IX_CMD, 8'h40);
    wr(`ATACD_IX_COUNT, pv[2]);
    for (i = 0; i < 29; i++) begin
      run(tbl[i][23:16], PM_IDLE);
      chk({7'h00, go}, 8'h01);
      if (c !== exp_cmd(tbl[i])) begin
        mismatches++;
        $display("[ERR] %0t issued command fields wrong for opcode %h", $time, tbl[i][23:16]);
      end
      n_checks++;
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      eng_code <= i[0] ? 8'h05 : `ATACD_DIAG_OK;
      run(OP_DIAG, PM_IDLE);
      chk({7'h00, c.drive}, 8'h01);
      chk({7'h00, err}, {7'h00, i[0]});
      rdchk(`ATACD_IX_ERROR, i[0] ? 8'h05 : `ATACD_DIAG_OK);
      rdchk(`ATACD_IX_CMD, i[0] ? 8'h41 : 8'h40);
    end
    @(posedge clk);
    eng_delay <= 4'hA;
    wr(`ATACD_IX_CMD, OP_SETM);
    wr(`ATACD_IX_COUNT, 8'h77);
    wait_done();
    rdchk(`ATACD_IX_COUNT, pv[2]);
    for (i = 0; i < 3; i++) begin
      run(bad[i], PM_IDLE);
      chk({7'h00, go}, 8'h00);
      chk({7'h00, err}, 8'h01);
      rdchk(`ATACD_IX_ERROR, `ATACD_ERR_ABORT);
      rdchk(`ATACD_IX_CMD, 8'h41);
      rdchk(`ATACD_IX_SECTOR, pv[3]);
    end
    run(OP_SETF, PM_IDLE);
    chk({7'h00, err}, 8'h00);
    rdchk(`ATACD_IX_CMD, 8'h40);
    tally_and_finish();
  end
endmodule
